// >>> rtl/lcc_bank_acc.sv
// per-bank accumulation of step codes and saturated dimming code
`include "lcc_consts.svh"

module lcc_bank_acc (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clr,
  input  wire logic       step,
  input  wire logic [3:0] nib,
  input  wire logic       coarse,
  input  wire logic       load,
  input  wire logic       off,
  input  wire logic [7:0] base,
  output logic      [7:0] dim
);

  lcc_pkg::lcc_acc_st_t q;
  lcc_pkg::lcc_acc_st_t d;

  function automatic logic [7:0] sat(input logic signed [10:0] v);
    if (v < 11'sh000) sat = 8'h00;
    else if (v > `LCC_DIM_MAX) sat = 8'hff;
    else sat = v[7:0];
  endfunction

  logic signed [9:0]  stepv;
  logic signed [10:0] sum;

  always_comb begin
    d     = q;
    stepv = {{6{nib[3]}}, nib}; // RULE1
    if (coarse) begin
      stepv = stepv <<< 1; // RULE2
    end
    // one spare bit: full base plus the largest positive sum must not wrap
    sum = $signed({3'b000, base}) + $signed({q.acc[9], q.acc});
    if (clr) begin
      d.acc = 10'sh000;
    end else if (step) begin
      d.acc = q.acc + stepv; // RULE8
    end
    // zero at once on shutdown, so led_off never stands beside a live code
    if (load || off) begin
      d.dim = off ? 8'h00 : sat(sum); // RULE3 RULE13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dim = q.dim;

endmodule // lcc_bank_acc

// >>> rtl/lcc_consts.svh
// offsets, field positions, reset values of the correction logic
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH

`define LCC_IDX_STAT      10'h040
`define LCC_IDX_SHDN      10'h04a
`define LCC_IDX_COARSE    10'h04b
`define LCC_IDX_TBL_FIRST 10'h050
`define LCC_IDX_TBL_LAST  10'h07f
`define LCC_EN_BIT        5
`define LCC_ZERO_IDX      5'h0c
`define LCC_SHDN_RST      8'h00
`define LCC_COARSE_RST    8'h00
`define LCC_DIM_MAX       10'sh0ff

`endif

// >>> rtl/lcc_pkg.sv
// types of the temperature correction logic
package lcc_pkg;

  typedef enum logic [1:0] {
    LCC_IDLE,
    LCC_WALK,
    LCC_DONE
  } lcc_state_t;

  typedef struct packed {
    lcc_state_t       st;
    logic [4:0]       idx;
    logic [4:0]       tgt;
    logic [4:0]       temp;
    logic             off;
    logic [7:0]       shdn;
    logic [7:0]       coarse;
    logic [47:0][7:0] tbl;
    logic [31:0]      prdata;
  } lcc_top_st_t;

  typedef struct packed {
    logic signed [9:0] acc;
    logic [7:0]        dim;
  } lcc_acc_st_t;

endpackage

// >>> rtl/lcc_top.sv
// temperature correction logic: apb registers, tables, sweep of step codes
//
// How it works
// (RULE1) each table entry is a 4-bit signed step count; 1101 is minus three
// (RULE2) coarse scale doubles each step, about 0.34 dB
// (RULE3) temperature above shutdown threshold forces led current to zero
// (RULE4) shutdown register: index in bits 4..0, enable in bit 5, e.g. 38h
// (RULE5) table points inside the shutdown region never affect the output; with a threshold below point 12, walks down still sum points above it
// (RULE6) scale register: index bits 4..0, enable bit 5; coarse from that index up
// (RULE7) temperature points are named by a 5-bit index code
// (RULE8) correction is the sum of steps from zero reference to the temperature
// (RULE9) tables are 4-bit signed entries packed in bytes 50h..7Fh
// (RULE10) above 25 deg entries step up from lower point, below from higher point
// (RULE11) fine scale step is about 0.17 dB, one dimming code
// (RULE12) a byte holds two points, lower temperature in the low nibble
// (RULE13) corrected dimming code saturates instead of wrapping
//
// Decided for this implementation: register access over APB.
`include "lcc_consts.svh"

module lcc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  temp_code,
  input  wire logic [7:0]  dim_base_a,
  input  wire logic [7:0]  dim_base_b,
  input  wire logic [7:0]  dim_base_c,
  output logic      [7:0]  dim_code_a,
  output logic      [7:0]  dim_code_b,
  output logic      [7:0]  dim_code_c,
  output logic             led_off
);

  lcc_pkg::lcc_top_st_t q;
  lcc_pkg::lcc_top_st_t d;

  // two points per byte, 16 bytes per bank
  function automatic logic [3:0] get_nib(input logic [47:0][7:0] t,
                                         input logic [1:0] bank,
                                         input logic [4:0] idx);
    logic [5:0] b;
    b = 6'({bank, 4'h0}) + 6'(idx[4:1]);
    get_nib = idx[0] ? t[b][7:4] : t[b][3:0]; // RULE12
  endfunction

  function automatic logic hit_of(input logic [11:0] a);
    logic [9:0] i;
    i      = a[11:2];
    hit_of = 1'b0;
    if (a[1:0] == 2'b00) begin
      case (i)
        `LCC_IDX_STAT, `LCC_IDX_SHDN, `LCC_IDX_COARSE: begin
          hit_of = 1'b1;
        end
        default: begin
          hit_of = (i >= `LCC_IDX_TBL_FIRST) && (i <= `LCC_IDX_TBL_LAST);
        end
      endcase
    end
  endfunction

  logic [9:0] ridx;
  logic [5:0] tb;
  logic       hit;
  logic       clr;
  logic       step;
  logic       load;
  logic [4:0] sidx;
  logic       coarse_on;
  logic [7:0] dim_base [3];
  logic [7:0] dim_out  [3];
  logic       rd_setup;
  logic       wr_take;
  logic [3:0] nib_sel  [3];

  assign dim_base[0] = dim_base_a;
  assign dim_base[1] = dim_base_b;
  assign dim_base[2] = dim_base_c;

  // setup cycle loads read data, access cycle commits a write
  assign rd_setup = psel && !penable;
  assign wr_take  = psel && penable && pwrite && pstrb[0];

  // one nibble per bank at the point the sweep is about to add
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nib_sel[i] = get_nib(q.tbl, 2'(i), sidx); // RULE12
    end
  end

  always_comb begin
    d    = q;
    clr  = 1'b0;
    step = 1'b0;
    load = 1'b0;
    sidx = q.idx;
    ridx = paddr[11:2];
    tb   = 6'(ridx - `LCC_IDX_TBL_FIRST);
    hit  = hit_of(paddr);

    // read data prepared in setup, shown in access
    if (rd_setup) begin
      d.prdata = 32'h0000_0000;
      if (hit) begin
        case (ridx)
          `LCC_IDX_STAT: begin
            d.prdata = {22'h00_0000, q.st != lcc_pkg::LCC_IDLE, q.off,
                        3'h0, q.temp}; // RULE7
          end
          `LCC_IDX_SHDN: begin
            d.prdata = {24'h00_0000, q.shdn}; // RULE4
          end
          `LCC_IDX_COARSE: begin
            d.prdata = {24'h00_0000, q.coarse}; // RULE6
          end
          default: begin
            d.prdata = {24'h00_0000, q.tbl[tb]}; // RULE9
          end
        endcase
      end
    end

    // a clear low strobe drops the write; status is read only
    if (wr_take && hit) begin
      case (ridx)
        `LCC_IDX_STAT: begin
        end
        `LCC_IDX_SHDN: begin
          d.shdn = pwdata[7:0]; // RULE4
        end
        `LCC_IDX_COARSE: begin
          d.coarse = pwdata[7:0]; // RULE6
        end
        default: begin
          d.tbl[tb] = pwdata[7:0]; // RULE9
        end
      endcase
    end

    case (q.st)
      lcc_pkg::LCC_IDLE: begin
        // threshold written mid-sweep takes effect from the next sweep
        d.temp = temp_code; // RULE7
        d.off  = q.shdn[`LCC_EN_BIT] && (temp_code > q.shdn[4:0]); // RULE3
        // shut off means no walk; shutdown-region entries are read only by walks down past a threshold below point 12
        d.tgt  = d.off ? `LCC_ZERO_IDX : temp_code; // RULE5
        d.idx  = `LCC_ZERO_IDX;
        clr    = 1'b1;
        d.st   = lcc_pkg::LCC_WALK;
      end
      lcc_pkg::LCC_WALK: begin
        if (q.idx == q.tgt) begin
          load = 1'b1;
          d.st = lcc_pkg::LCC_DONE;
        end else begin
          // the zero point itself is never summed; walk outward from it
          sidx  = (q.idx < q.tgt) ? q.idx + 5'h01 : q.idx - 5'h01; // RULE10
          d.idx = sidx;
          step  = 1'b1; // RULE8
        end
      end
      lcc_pkg::LCC_DONE: begin
        d.st = lcc_pkg::LCC_IDLE;
      end
      default: begin
        d.st = lcc_pkg::LCC_IDLE;
      end
    endcase
    coarse_on = q.coarse[`LCC_EN_BIT] && (sidx >= q.coarse[4:0]); // RULE6 RULE11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.st     <= lcc_pkg::LCC_IDLE;
      q.idx    <= `LCC_ZERO_IDX;
      q.tgt    <= `LCC_ZERO_IDX;
      q.shdn   <= `LCC_SHDN_RST;
      q.coarse <= `LCC_COARSE_RST;
    end else begin
      q <= d;
    end
  end

  // banks share the sweep control; only the table nibble and base differ
  for (genvar g = 0; g < 3; g++) begin : g_bank
    lcc_bank_acc u_acc (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (clr),
      .step    (step),
      .nib     (nib_sel[g]),
      .coarse  (coarse_on),
      .load    (load),
      .off     (d.off),
      .base    (dim_base[g]),
      .dim     (dim_out[g])
    );
  end

  assign dim_code_a = dim_out[0];
  assign dim_code_b = dim_out[1];
  assign dim_code_c = dim_out[2];
  assign led_off    = q.off;
  assign prdata     = q.prdata;
  // zero wait states: every register answers from flops in one cycle
  assign pready     = 1'b1;
  // unmapped or misaligned access answers with an error, write dropped
  assign pslverr    = psel && penable && !hit;

endmodule // lcc_top

// >>> test/lcc_chk.sv
// protocol and shutdown checks on the correction logic ports
module lcc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [4:0]  temp_code,
  input wire logic [7:0]  dim_code_a,
  input wire logic [7:0]  dim_code_b,
  input wire logic [7:0]  dim_code_c,
  input wire logic        led_off
);
  logic [7:0] sh_q;
  logic [5:0] cnt_q;
  logic       want_q;
  logic       want;
  // shadow of the shutdown register; one sweep plus one load is under 50 cycles
  assign want = sh_q[5] && (temp_code > sh_q[4:0]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q   <= 8'h00;
      cnt_q  <= 6'h00;
      want_q <= 1'b0;
    end else begin
      if (psel && penable && pwrite && pstrb[0] && paddr == 12'h128) sh_q <= pwdata[7:0];
      want_q <= want;
      cnt_q  <= (want != want_q) ? 6'h00 : ((cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_align: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_tbl_ok: assert property (psel && penable && paddr >= 12'h140 && paddr <= 12'h1fc
    && paddr[1:0] == 2'b00 |-> !pslverr) else $error("table access refused");
  a_err_idle: assert property (!penable |-> !pslverr) else $error("error outside access");
  a_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:10] == 22'h0
    && (paddr == 12'h100 || prdata[9:8] == 2'b00)) else $error("upper read bits set");
  a_shdn_rd: assert property (psel && penable && !pwrite && paddr == 12'h128
    |-> prdata[7:0] == sh_q) else $error("shutdown readback wrong");
  a_off_dims: assert property (led_off |-> {dim_code_a, dim_code_b, dim_code_c} == 24'h0)
    else $error("dims not zero in shutdown");
  a_off_follow: assert property (cnt_q == 6'd50 |-> led_off == want)
    else $error("shutdown flag does not follow temperature");
endmodule // lcc_chk

bind lcc_top lcc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .temp_code(temp_code), .dim_code_a(dim_code_a),
  .dim_code_b(dim_code_b), .dim_code_c(dim_code_c), .led_off(led_off));

// >>> test/test_led_temp_lut_correction.sv
// self-checking bench: random tables, both threshold settings, every temperature
module test_led_temp_lut_correction;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [3:0]  pstrb = 4'hf;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, er, led_off;
  logic [4:0]  temp_code = 5'h00;
  logic [7:0]  dim_base_a = 8'h00, dim_base_b = 8'h00, dim_base_c = 8'h00;
  logic [7:0]  dim_code_a, dim_code_b, dim_code_c;
  int          mismatches = 0, total_checks = 0, k, sh, co, m[48], b[3];
  always #5 pclk = ~pclk;
  lcc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .temp_code(temp_code), .dim_base_a(dim_base_a),
    .dim_base_b(dim_base_b), .dim_base_c(dim_base_c), .dim_code_a(dim_code_a),
    .dim_code_b(dim_code_b), .dim_code_c(dim_code_c), .led_off(led_off));
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic xf(input bit w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin mismatches++; conclude(); end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  // signed nibbles summed outward from point 12, coarse points doubled
  function automatic int ex(int bk, int t, int base);
    int c = base, s;
    for (int n = 0; n < 32; n++) if ((t > 12 && n > 12 && n <= t) || (t < 12 && n >= t && n < 12)) begin
      s = (m[bk*16+n/2] >> (n % 2 * 4)) & 15;
      if (s > 7) s -= 16;
      c += (co[5] && n >= co[4:0]) ? 2 * s : s;
    end
    return (sh[5] && t > sh[4:0]) ? 0 : (c < 0 ? 0 : (c > 255 ? 255 : c));
  endfunction
  initial begin
    k = $urandom(74736);
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 48; i++) begin
      m[i] = $urandom & 255;
      xf(1, 12'h140 + 12'(4 * i), m[i]);
    end
    xf(0, 12'h1a4, 0); chk(rd, m[25]);
    xf(0, 12'h129, 0);
    chk(er, 1);
    chk(rd, 0);
    for (int p = 0; p < 2; p++) begin
      sh = p ? 8'h38 : 8'h00;
      co = p ? 8'h33 : 8'h00;
      xf(1, 12'h128, sh); xf(1, 12'h12c, co);
      xf(0, 12'h12c, 0); chk(rd, co);
      // a write with the low strobe clear must leave the register alone
      pstrb <= 4'he;
      xf(1, 12'h12c, 32'h0000_003f);
      pstrb <= 4'hf;
      xf(0, 12'h12c, 0);
      chk(rd, co);
      for (int t = 0; t < 32; t++) begin
        foreach (b[j]) b[j] = $urandom & 255;
        temp_code <= 5'(t); dim_base_a <= 8'(b[0]); dim_base_b <= 8'(b[1]); dim_base_c <= 8'(b[2]);
        repeat (60) @(posedge pclk);
        chk(dim_code_a, ex(0, t, b[0]));
        chk(dim_code_b, ex(1, t, b[1]));
        chk(dim_code_c, ex(2, t, b[2]));
        chk(led_off, sh[5] && t > sh[4:0]);
        // status: temperature and shutdown flag; busy bit depends on sweep phase
        xf(0, 12'h100, 0);
        chk(rd & 32'hffff_fdff, 32'(t) | (32'(sh[5] && t > sh[4:0]) << 8));
      end
    end
    conclude();
  end
endmodule // test_led_temp_lut_correction
